// ==== rtl/eor_consts.vh ====
`ifndef EOR_CONSTS_VH
`define EOR_CONSTS_VH
// geometry
`define EOR_NUM_EDGE        4
`define EOR_NUM_WIN         8
`define EOR_COORD_W         16
`define EOR_HIT_W           8
`define EOR_DEPTH_W         8
// analysis depth factory default
`define EOR_DEPTH_RESET     8'h01
// value selector codes
`define EOR_SEL_LX          3'h0
`define EOR_SEL_LZ          3'h1
`define EOR_SEL_RX          3'h2
`define EOR_SEL_RZ          3'h3
`define EOR_SEL_W           3'h4
`define EOR_SEL_H           3'h5
// scan timing
`define EOR_CLK_HZ          40000000
`define EOR_SCAN_MS         10
`define EOR_SCAN_CYC        ((`EOR_CLK_HZ / 1000) * `EOR_SCAN_MS)
`endif

// ==== rtl/eor_debounce.v ====
`timescale 1ns/1ps
`include "eor_consts.vh"
// consecutive-evaluation filter for the object and result
module eor_debounce (
  // clock and reset
  input  wire                    i_sys_clk,
  input  wire                    i_rst_n,
  // evaluation strobe and raw result
  input  wire                    i_eval,
  input  wire                    i_raw,
  input  wire [`EOR_DEPTH_W-1:0] i_depth,
  // filtered result
  output reg                     o_result
);
  reg [`EOR_DEPTH_W-1:0] cnt_reg;   // consecutive equal new results
  reg                    prev_reg;  // previous raw result
  wire [`EOR_DEPTH_W-1:0] need;     // depth 0 treated as 1
  assign need = (i_depth == 8'h00) ? 8'h01 : i_depth;

  // count runs of a new raw value, switch after depth evaluations
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_reg  <= 8'h00;
      prev_reg <= 1'b0;
      o_result <= 1'b0;
    end else if (i_eval) begin
      prev_reg <= i_raw;
      if (i_raw == o_result) begin
        cnt_reg <= 8'h00;
      end else if ((i_raw != prev_reg) && (cnt_reg != 8'h00)) begin
        cnt_reg <= 8'h01;
        if (need == 8'h01) begin
          o_result <= i_raw;
          cnt_reg  <= 8'h00;
        end
      end else if (cnt_reg + 8'h01 >= need) begin
        o_result <= i_raw;
        cnt_reg  <= 8'h00;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end
endmodule // eor_debounce

// ==== rtl/eor_edge_result.v ====
`timescale 1ns/1ps
`include "eor_consts.vh"
// Behaviour
// - final edge result is edge AND object
// - no object config: edge state alone
// - separate left and right edge plausibility
// - edge values valid only when edge ok
// - analog value valid only when final ok
// - width is right X minus left X
// - height is right Z minus left Z
// - six millimetre values per edge window
// - two selectable fieldbus values per window
// - AND of selected windows with polarity
// - only enabled windows join the AND
// - result changes after depth equal evaluations
// - one evaluation per ten millisecond scan
// - analysis depth defaults to one
// - settings take effect only when applied
// - edge detected when run reaches threshold
// - object state hysteresis with on/off thresholds
module eor_edge_result #(
  parameter SCAN_CYC = `EOR_SCAN_CYC
) (
  // clock and reset
  input  wire         i_sys_clk,
  input  wire         i_rst_n,
  // per-window measurements, packed window 0 lowest
  input  wire [31:0]  i_run_left,      // 4 x 8 consecutive hits left
  input  wire [31:0]  i_run_right,     // 4 x 8 consecutive hits right
  input  wire [63:0]  i_hits,          // 8 x 8 hit counts, edge windows first
  input  wire [63:0]  i_left_edge_x,   // 4 x 16 mm coordinates
  input  wire [63:0]  i_left_edge_z,
  input  wire [63:0]  i_right_edge_x,
  input  wire [63:0]  i_right_edge_z,
  // staged configuration
  input  wire [3:0]   i_cfg_edge_en,   // edge window active
  input  wire [31:0]  i_cfg_seq_hits,  // 4 x 8 consecutive-hit threshold
  input  wire [7:0]   i_cfg_obj_en,    // object detection enable
  input  wire [7:0]   i_cfg_use,       // window selected in AND
  input  wire [7:0]   i_cfg_invert,    // 1 selects inverted polarity
  input  wire [63:0]  i_cfg_hits_on,   // 8 x 8
  input  wire [63:0]  i_cfg_hits_off,  // 8 x 8
  input  wire [7:0]   i_cfg_depth,     // analysis depth
  input  wire [11:0]  i_cfg_sel1,      // 4 x 3 fieldbus value 1 select
  input  wire [11:0]  i_cfg_sel2,      // 4 x 3 fieldbus value 2 select
  input  wire [1:0]   i_cfg_an_edge,   // analog source window
  input  wire [2:0]   i_cfg_an_sel,    // analog source value
  input  wire         i_apply,         // transfer staged settings
  // scan timing
  output reg          o_scan_tick,     // one-cycle evaluation strobe
  // results
  output reg  [3:0]   o_left_ok,
  output reg  [3:0]   o_right_ok,
  output reg  [3:0]   o_edge_state,
  output reg  [3:0]   o_final_state,
  output reg  [7:0]   o_obj_state,
  output wire         o_object_and_result,
  output wire         o_debounced_object_result,
  // measurement values
  output reg  [63:0]  o_width,
  output reg  [63:0]  o_height,
  output reg  [63:0]  o_pd_val1,
  output reg  [63:0]  o_pd_val2,
  output reg  [3:0]   o_pd_valid,
  output reg  [15:0]  o_analog_val,
  output reg          o_analog_valid
);
  // applied configuration copies
  reg [3:0]  edge_en_reg;
  reg [31:0] seq_reg;
  reg [7:0]  obj_en_reg;
  reg [7:0]  use_reg;
  reg [7:0]  inv_reg;
  reg [63:0] on_reg;
  reg [63:0] off_reg;
  reg [7:0]  depth_reg;
  reg [11:0] sel1_reg;
  reg [11:0] sel2_reg;
  reg [1:0]  an_edge_reg;
  reg [2:0]  an_sel_reg;
  // scan counter
  reg [31:0] scan_cnt_reg;
  // combinational per-window terms
  wire [3:0]  left_det;
  wire [3:0]  right_det;
  wire [7:0]  obj_next;
  wire [7:0]  and_terms;
  wire        obj_any;
  wire [63:0] w_calc;
  wire [63:0] h_calc;

  // pick one of the six values
  function [15:0] pick;
    input [2:0]  sel;
    input [15:0] lx;
    input [15:0] lz;
    input [15:0] rx;
    input [15:0] rz;
    input [15:0] w;
    input [15:0] h;
    begin
      case (sel)
        `EOR_SEL_LX: pick = lx;
        `EOR_SEL_LZ: pick = lz;
        `EOR_SEL_RX: pick = rx;
        `EOR_SEL_RZ: pick = rz;
        `EOR_SEL_W:  pick = w;
        `EOR_SEL_H:  pick = h;
        default:     pick = 16'h0000;
      endcase
    end
  endfunction

  // configuration only takes effect on apply
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      edge_en_reg <= 4'h0;
      seq_reg     <= 32'h0000_0000;
      obj_en_reg  <= 8'h00;
      use_reg     <= 8'h00;
      inv_reg     <= 8'h00;
      on_reg      <= 64'h0;
      off_reg     <= 64'h0;
      depth_reg   <= `EOR_DEPTH_RESET;
      sel1_reg    <= 12'h000;
      sel2_reg    <= 12'h000;
      an_edge_reg <= 2'h0;
      an_sel_reg  <= 3'h0;
    end else if (i_apply) begin
      edge_en_reg <= i_cfg_edge_en;
      seq_reg     <= i_cfg_seq_hits;
      obj_en_reg  <= i_cfg_obj_en;
      use_reg     <= i_cfg_use;
      inv_reg     <= i_cfg_invert;
      on_reg      <= i_cfg_hits_on;
      off_reg     <= i_cfg_hits_off;
      depth_reg   <= i_cfg_depth;
      sel1_reg    <= i_cfg_sel1;
      sel2_reg    <= i_cfg_sel2;
      an_edge_reg <= i_cfg_an_edge;
      an_sel_reg  <= i_cfg_an_sel;
    end
  end

  // scan tick every 10 ms
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      scan_cnt_reg <= 32'h0000_0000;
      o_scan_tick  <= 1'b0;
    end else if (scan_cnt_reg == SCAN_CYC - 1) begin
      scan_cnt_reg <= 32'h0000_0000;
      o_scan_tick  <= 1'b1;
    end else begin
      scan_cnt_reg <= scan_cnt_reg + 32'h0000_0001;
      o_scan_tick  <= 1'b0;
    end
  end

  // per edge window detection and geometry
  genvar g;
  generate
    for (g = 0; g < `EOR_NUM_EDGE; g = g + 1) begin : g_edge
      assign left_det[g]  = edge_en_reg[g] &&
                            (i_run_left[g*8 +: 8] >= seq_reg[g*8 +: 8]);
      assign right_det[g] = edge_en_reg[g] &&
                            (i_run_right[g*8 +: 8] >= seq_reg[g*8 +: 8]);
      assign w_calc[g*16 +: 16] = i_right_edge_x[g*16 +: 16] -
                                  i_left_edge_x[g*16 +: 16];
      assign h_calc[g*16 +: 16] = i_right_edge_z[g*16 +: 16] -
                                  i_left_edge_z[g*16 +: 16];
    end
    // object state hysteresis and AND terms
    for (g = 0; g < `EOR_NUM_WIN; g = g + 1) begin : g_obj
      assign obj_next[g] = !obj_en_reg[g] ? 1'b0 :
                           (i_hits[g*8 +: 8] >= on_reg[g*8 +: 8]) ? 1'b1 :
                           (i_hits[g*8 +: 8] <= off_reg[g*8 +: 8]) ? 1'b0 :
                           o_obj_state[g];
      assign and_terms[g] = !(use_reg[g] && obj_en_reg[g]) ? 1'b1 :
                            (o_obj_state[g] ^ inv_reg[g]);
    end
  endgenerate

  assign o_object_and_result = &and_terms;
  assign obj_any = |(use_reg & obj_en_reg);

  // filter the AND result once per scan
  eor_debounce u_deb (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_eval    (o_scan_tick),
    .i_raw     (o_object_and_result),
    .i_depth   (depth_reg),
    .o_result  (o_debounced_object_result)
  );

  // result and value registers, updated every cycle; object state once per scan
  integer k;
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_left_ok      <= 4'h0;
      o_right_ok     <= 4'h0;
      o_edge_state   <= 4'h0;
      o_final_state  <= 4'h0;
      o_obj_state    <= 8'h00;
      o_width        <= 64'h0;
      o_height       <= 64'h0;
      o_pd_val1      <= 64'h0;
      o_pd_val2      <= 64'h0;
      o_pd_valid     <= 4'h0;
      o_analog_val   <= 16'h0000;
      o_analog_valid <= 1'b0;
    end else begin
      if (o_scan_tick) begin
        o_obj_state <= obj_next;
      end
      o_left_ok    <= left_det;
      o_right_ok   <= right_det;
      o_edge_state <= left_det | right_det;
      o_width      <= w_calc;
      o_height     <= h_calc;
      for (k = 0; k < `EOR_NUM_EDGE; k = k + 1) begin
        // gate by debounced object result when any object window is used
        o_final_state[k] <= (left_det[k] | right_det[k]) &
                            (obj_any ? o_debounced_object_result : 1'b1);
        o_pd_valid[k] <= left_det[k] | right_det[k];
        o_pd_val1[k*16 +: 16] <= pick(sel1_reg[k*3 +: 3],
          i_left_edge_x[k*16 +: 16], i_left_edge_z[k*16 +: 16],
          i_right_edge_x[k*16 +: 16], i_right_edge_z[k*16 +: 16],
          w_calc[k*16 +: 16], h_calc[k*16 +: 16]);
        o_pd_val2[k*16 +: 16] <= pick(sel2_reg[k*3 +: 3],
          i_left_edge_x[k*16 +: 16], i_left_edge_z[k*16 +: 16],
          i_right_edge_x[k*16 +: 16], i_right_edge_z[k*16 +: 16],
          w_calc[k*16 +: 16], h_calc[k*16 +: 16]);
      end
      // analog value only while final state of chosen window is ok
      o_analog_valid <= o_final_state[an_edge_reg];
      o_analog_val   <= o_final_state[an_edge_reg] ?
        pick(an_sel_reg,
          i_left_edge_x[an_edge_reg*16 +: 16], i_left_edge_z[an_edge_reg*16 +: 16],
          i_right_edge_x[an_edge_reg*16 +: 16], i_right_edge_z[an_edge_reg*16 +: 16],
          w_calc[an_edge_reg*16 +: 16], h_calc[an_edge_reg*16 +: 16]) :
        16'h0000;
    end
  end
endmodule // eor_edge_result

// ==== sim/eor_edge_result_sva.sv ====
`timescale 1ns/1ps
// port-level checker for the edge and object result block
module eor_edge_result_sva #(
  parameter SCAN_CYC = 8
) (
  // clock and reset
  input wire        i_sys_clk,
  input wire        i_rst_n,
  // coordinates
  input wire [63:0] i_left_edge_x,
  input wire [63:0] i_right_edge_x,
  input wire [63:0] i_left_edge_z,
  input wire [63:0] i_right_edge_z,
  // results
  input wire        o_scan_tick,
  input wire [3:0]  o_left_ok,
  input wire [3:0]  o_right_ok,
  input wire [3:0]  o_edge_state,
  input wire [3:0]  o_final_state,
  input wire [7:0]  o_obj_state,
  input wire        o_debounced_object_result,
  input wire [63:0] o_width,
  input wire [63:0] o_height,
  input wire [3:0]  o_pd_valid,
  input wire [15:0] o_analog_val,
  input wire        o_analog_valid
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // window 0 width and window 3 height track their coordinates
  width_calc_a: assert property ($past(i_rst_n) |->
    o_width[15:0] == $past(i_right_edge_x[15:0] - i_left_edge_x[15:0])) else $error("width");
  height_calc_a: assert property ($past(i_rst_n) |->
    o_height[63:48] == $past(i_right_edge_z[63:48] - i_left_edge_z[63:48])) else $error("height");
  edge_or_a: assert property (o_edge_state == (o_left_ok | o_right_ok))
    else $error("edge state");
  pd_valid_a: assert property (o_pd_valid == o_edge_state) else $error("pd valid");
  final_gate_a: assert property ($past(i_rst_n) |->
    (o_final_state & ~(o_edge_state | $past(o_edge_state))) == 4'h0) else $error("final");
  analog_zero_a: assert property (!o_analog_valid |-> o_analog_val == 16'h0000)
    else $error("analog value");
  analog_valid_a: assert property (o_analog_valid |-> $past(|o_final_state))
    else $error("analog valid");
  obj_tick_a: assert property ($past(i_rst_n) && $changed(o_obj_state) |->
    $past(o_scan_tick)) else $error("object state");
  deb_tick_a: assert property ($past(i_rst_n) && $changed(o_debounced_object_result) |->
    $past(o_scan_tick)) else $error("debounce");
  tick_period_a: assert property (o_scan_tick |=> !o_scan_tick [*7] ##1 o_scan_tick)
    else $error("tick period");
  // main scenarios
  cover property (o_scan_tick);
  cover property ($rose(o_debounced_object_result));
  cover property (o_analog_valid);
endmodule // eor_edge_result_sva

bind eor_edge_result eor_edge_result_sva #(.SCAN_CYC(SCAN_CYC)) sva_u (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_left_edge_x(i_left_edge_x),
  .i_right_edge_x(i_right_edge_x), .i_left_edge_z(i_left_edge_z),
  .i_right_edge_z(i_right_edge_z), .o_scan_tick(o_scan_tick), .o_left_ok(o_left_ok),
  .o_right_ok(o_right_ok), .o_edge_state(o_edge_state), .o_final_state(o_final_state),
  .o_obj_state(o_obj_state), .o_debounced_object_result(o_debounced_object_result),
  .o_width(o_width), .o_height(o_height), .o_pd_valid(o_pd_valid),
  .o_analog_val(o_analog_val), .o_analog_valid(o_analog_valid));

// ==== sim/eor_pd_sink.sv ====
`timescale 1ns/1ps
// controller side: keeps the last valid fieldbus value 1 of each window
module eor_pd_sink (
  // clock
  input  wire        i_sys_clk,
  // process data
  input  wire [3:0]  i_valid,
  input  wire [63:0] i_val,
  // last accepted values
  output reg  [63:0] o_held
);
  integer j;
  // take a window's value only while it is flagged valid
  always @(posedge i_sys_clk) begin
    for (j = 0; j < 4; j = j + 1) begin
      if (i_valid[j]) o_held[16*j +: 16] <= i_val[16*j +: 16];
    end
  end
endmodule // eor_pd_sink

// ==== sim/eor_edge_result_test.sv ====
`timescale 1ns/1ps
`include "eor_consts.vh"
// bench for the edge and object result block
module eor_edge_result_test;
  // stimulus
  reg         clk, rst_n, apply;
  reg  [31:0] run_l, run_r, seq;
  reg  [63:0] hits, lx, lz, rx, rz, h_on, h_off;
  reg  [7:0]  o_en, usel, inv, depth;
  reg  [3:0]  e_en;
  reg  [2:0]  an_s;
  // observed
  wire        tick, andr, deb, avld;
  wire [3:0]  lok, rok, es, fs, pv;
  wire [7:0]  os;
  wire [63:0] wd, ht, p1, p2, held;
  wire [15:0] av;
  // bookkeeping
  integer     mismatches, cmp_count, cyc, i, n, k;
  reg  [81:0] rows [0:3];
  reg         el, er;
  reg  [7:0]  a, b;
  reg  [15:0] c, d, e, f, w, h;
  reg  [63:0] last;

  eor_edge_result #(.SCAN_CYC(8)) dut_u (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_run_left(run_l), .i_run_right(run_r),
    .i_hits(hits), .i_left_edge_x(lx), .i_left_edge_z(lz), .i_right_edge_x(rx),
    .i_right_edge_z(rz), .i_cfg_edge_en(e_en), .i_cfg_seq_hits(seq), .i_cfg_obj_en(o_en),
    .i_cfg_use(usel), .i_cfg_invert(inv), .i_cfg_hits_on(h_on), .i_cfg_hits_off(h_off),
    .i_cfg_depth(depth), .i_cfg_sel1({`EOR_SEL_RZ, `EOR_SEL_RX, `EOR_SEL_LZ, `EOR_SEL_LX}),
    .i_cfg_sel2({3'h7, 3'h6, `EOR_SEL_H, `EOR_SEL_W}), .i_cfg_an_edge(2'h0),
    .i_cfg_an_sel(an_s), .i_apply(apply), .o_scan_tick(tick), .o_left_ok(lok),
    .o_right_ok(rok), .o_edge_state(es), .o_final_state(fs), .o_obj_state(os),
    .o_object_and_result(andr), .o_debounced_object_result(deb), .o_width(wd),
    .o_height(ht), .o_pd_val1(p1), .o_pd_val2(p2), .o_pd_valid(pv), .o_analog_val(av),
    .o_analog_valid(avld));
  eor_pd_sink sink_u (.i_sys_clk(clk), .i_valid(pv), .i_val(p1), .o_held(held));

  // advance edges, then let updates settle
  task step(input integer m); begin
    repeat (m) @(posedge clk);
    #2;
  end endtask
  // pass a number of scan ticks
  task tk(input integer m); begin
    repeat (m) begin
      while (tick !== 1'b1) step(1);
      step(1);
    end
  end endtask
  // transfer staged settings
  task go; begin
    apply = 1'b1;
    step(1);
    apply = 1'b0;
  end endtask
  // compare and count
  task chk(input [63:0] got, input [63:0] exp); begin
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  end endtask
  // verdict
  task results; begin
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  end endtask

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      mismatches = mismatches + 1;
      results;
    end
  end

  initial begin
    {mismatches, cmp_count, cyc, rst_n, apply} = 0;
    {run_l, run_r, seq, hits} = {{4{8'hFF}}, 32'h0, {4{8'h05}}, {8{8'h14}}};
    {lx, lz, rx, rz, h_on, h_off} = {256'h0, {8{8'h0A}}, {8{8'h05}}};
    {o_en, usel, inv, depth, e_en, an_s} = {24'h0, 8'h03, 4'hF, `EOR_SEL_W};
    // left/right expected, runs, lx rx lz rz
    rows[0] = {2'b10, 8'h05, 8'h00, 16'h0010, 16'h0030, 16'h0100, 16'h0105};
    rows[1] = {2'b01, 8'h00, 8'h06, 16'h0010, 16'h0005, 16'h0200, 16'h0100};
    rows[2] = {2'b11, 8'hFF, 8'hFF, 16'hFFF0, 16'h0008, 16'h0001, 16'hFFFF};
    rows[3] = {2'b00, 8'h04, 8'h04, 16'h1234, 16'h4321, 16'h0300, 16'h0300};
    step(2);
    rst_n = 1'b1;
    step(3);
    chk(lok, 0);
    go;
    for (i = 0; i < 4; i = i + 1) begin
      {el, er, a, b, c, d, e, f} = rows[i];
      {run_l, run_r, lx, rx, lz, rz} = {{4{a}}, {4{b}}, {4{c}}, {4{d}}, {4{e}}, {4{f}}};
      w = d - c;
      h = f - e;
      step(3);
      chk(lok, {4{el}});
      chk(rok, {4{er}});
      chk(wd, {4{w}});
      chk(ht, {4{h}});
      chk(p1, {f, d, e, c});
      chk(p2, {32'h0, h, w});
      chk(pv, {4{el | er}});
      chk(fs, {4{el | er}});
      if (el | er) last = {f, d, e, c};
    end
    chk(held, last);
    // object AND through window 0, depth three
    // the empty AND has run the filter count to two of three, so first drive it low
    {run_l, o_en, usel, hits} = {{4{8'hFF}}, 8'h01, 8'h01, {8{8'h05}}};
    go;
    tk(4);
    chk(deb, 0);
    hits = {8{8'h14}};
    {n, k} = 0;
    while (deb !== 1'b1 && k < 12) begin
      while (tick !== 1'b1) step(1);
      if (andr === 1'b1) n = n + 1;
      step(1);
      k = k + 1;
    end
    chk(n, 3);
    step(2);
    chk(fs, 4'hF);
    chk({avld, av}, {1'b1, w});
    // hysteresis between off and on thresholds
    hits = {8{8'h07}};
    tk(2);
    chk(os[0], 1);
    hits = {8{8'h05}};
    tk(2);
    chk(os[0], 0);
    tk(4);
    step(3);
    chk(fs, 4'h0);
    chk({avld, av}, 0);
    inv = 8'h01;
    go;
    tk(2);
    chk(andr, 1);
    o_en = 8'h00;
    go;
    step(3);
    chk(fs, 4'hF);
    // reset in mid-run clears applied settings
    rst_n = 1'b0;
    step(2);
    chk({lok, deb, os, fs}, 0);
    rst_n = 1'b1;
    step(3);
    chk(lok, 0);
    results;
  end
endmodule // eor_edge_result_test
